// ---- rtl/pwdt_pkg.sv ----
// Package: port addresses, factor fields and timing constants of the watchdog
package pwdt_pkg;
   localparam logic [15:0] CMD_PORT_ADDR = 16'h0076;
   localparam logic [15:0] BASE_PORT_OFFSET = 16'h0004;
   localparam logic [15:0] VAR_DISABLE_ADDR = 16'h0441;
   localparam logic [15:0] VAR_PERIOD_ADDR = 16'h0443;
   localparam logic [7:0] FACTOR_DISABLE = 8'h00;
   localparam logic [7:0] VAR_DISABLE_CODE = 8'hff;
   localparam logic [7:0] VAR_CODE_MIN = 8'h01;
   localparam logic [7:0] VAR_CODE_MAX = 8'h04;
   localparam int EN_BIT = 7;
   localparam int IRQ_BIT = 6;
   localparam int IDX_HI = 2;
   localparam int IDX_LO = 0;
   localparam logic [7:0] FACTOR_FIXED_MASK = 8'h38;
   localparam logic [7:0] FACTOR_FIXED_VAL = 8'h00;
   localparam int CLK_HZ = 40_000_000;
   // Tenth-second ticks: 3 s is 30 ticks, variant 9.3 s is 93 ticks
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int SHORT_PERIOD_MS = 3000;
   localparam int UNIT_PERIOD_MS = 6000;
   localparam int VAR_UNIT_MS = 9300;
   localparam int SHORT_TICKS = SHORT_PERIOD_MS / TICK_MS;
   localparam int UNIT_TICKS = UNIT_PERIOD_MS / TICK_MS;
   localparam int VAR_UNIT_TICKS = VAR_UNIT_MS / TICK_MS;
   localparam int RESET_PULSE_US = 100;
   localparam int RESET_PULSE_CYC = CLK_HZ / 1_000_000 * RESET_PULSE_US;
   localparam int LED_HALF_MS = 500;
   localparam int LED_HALF_TICKS = LED_HALF_MS / TICK_MS;
   localparam int CNT_W = 12;
   typedef enum logic [1:0] {
      PWDT_IDLE = 2'b00,
      PWDT_COUNT = 2'b01,
      PWDT_FIRED = 2'b10
   } pwdt_state_t;
endpackage : pwdt_pkg

// ---- rtl/pwdt_tick_if.sv ----
// Interface: time-base tick and its enable between top and divider
`timescale 1ns/100ps
`default_nettype none
interface pwdt_tick_if;
   logic run;
   logic tick;
   modport src (input run, output tick);
   modport dst (output run, input tick);
endinterface : pwdt_tick_if
`default_nettype wire

// ---- rtl/pwdt_divider.sv ----
// Module: divider giving a one-cycle tick every DIV cycles while run is high
`timescale 1ns/100ps
`default_nettype none
module pwdt_divider #(
   parameter int DIV = pwdt_pkg::TICK_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   pwdt_tick_if.src tb
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic tick_q;
   logic tick_d;
   always_comb begin
      cnt_d = cnt_q;
      tick_d = 1'b0;
      // Restarting with run keeps the first tick a full period away
      if (!tb.run) begin
         cnt_d = '0;
      end else if (cnt_q == LAST) begin
         cnt_d = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + W'(1);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign tb.tick = tick_q;
endmodule : pwdt_divider
`default_nettype wire

// ---- rtl/pwdt_top.sv ----
// Module: programmable watchdog timer behind an I/O write port
`timescale 1ns/100ps
`default_nettype none
module pwdt_top #(
   parameter logic [15:0] BASE_PORT = 16'h0300,
   parameter int TICK_DIV = pwdt_pkg::TICK_CYC,
   parameter int RESET_PULSE_CYCLES = pwdt_pkg::RESET_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_write,
   output logic watchdog_system_reset,
   output logic watchdog_interrupt_line,
   output logic watchdog_led,
   output logic watchdog_enabled
);
   localparam int PW = $clog2(RESET_PULSE_CYCLES + 1);
   localparam logic [PW-1:0] PULSE_LEN = PW'(RESET_PULSE_CYCLES);
   localparam int CW = pwdt_pkg::CNT_W;
   localparam logic [CW-1:0] SHORT_T = CW'(pwdt_pkg::SHORT_TICKS);
   localparam logic [CW-1:0] UNIT_T = CW'(pwdt_pkg::UNIT_TICKS);
   localparam logic [CW-1:0] VAR_T = CW'(pwdt_pkg::VAR_UNIT_TICKS);
   localparam logic [CW-1:0] LED_T = CW'(pwdt_pkg::LED_HALF_TICKS);

   ////////////////////////////////////////////////////////////////////////
   // Write decode
   logic cmd_hit;
   logic var_dis_hit;
   logic var_per_hit;
   logic f_disable;
   logic f_valid;
   logic v_valid;
   logic [2:0] f_idx;
   logic f_irq;
   logic [CW-1:0] f_period;
   logic [CW-1:0] v_period;
   assign cmd_hit = io_write &&
      (io_addr == pwdt_pkg::CMD_PORT_ADDR || io_addr == BASE_PORT + pwdt_pkg::BASE_PORT_OFFSET);
   assign var_dis_hit = io_write && io_addr == pwdt_pkg::VAR_DISABLE_ADDR &&
      io_wdata == pwdt_pkg::VAR_DISABLE_CODE;
   assign var_per_hit = io_write && io_addr == pwdt_pkg::VAR_PERIOD_ADDR;
   assign f_disable = cmd_hit && io_wdata == pwdt_pkg::FACTOR_DISABLE;
   // Stray patterns are dropped so a corrupted write cannot change the period
   assign f_valid = cmd_hit && io_wdata[pwdt_pkg::EN_BIT] &&
      ((io_wdata & pwdt_pkg::FACTOR_FIXED_MASK) == pwdt_pkg::FACTOR_FIXED_VAL);
   assign v_valid = var_per_hit && io_wdata >= pwdt_pkg::VAR_CODE_MIN &&
      io_wdata <= pwdt_pkg::VAR_CODE_MAX;
   assign f_idx = io_wdata[pwdt_pkg::IDX_HI:pwdt_pkg::IDX_LO];
   assign f_irq = io_wdata[pwdt_pkg::IRQ_BIT];

   // Period in 100 ms ticks for a factor index
   function automatic logic [CW-1:0] ladder(input logic [2:0] idx);
      logic [CW-1:0] p;
      p = (idx == 3'h0) ? SHORT_T : CW'(UNIT_T * idx);
      return p;
   endfunction : ladder

   // Periods worked out at decode so the write cycle only registers them
   assign f_period = ladder(f_idx);
   assign v_period = CW'(VAR_T * f_idx);

   ////////////////////////////////////////////////////////////////////////
   // Time base
   pwdt_tick_if tb ();
   pwdt_divider #(
      .DIV(TICK_DIV)
   ) u_div (
      .sys_clk(sys_clk),
      .reset(reset),
      .tb(tb)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control state
   pwdt_pkg::pwdt_state_t state_q;
   pwdt_pkg::pwdt_state_t state_d;
   logic irq_mode_q;
   logic irq_mode_d;
   logic [CW-1:0] period_q;
   logic [CW-1:0] period_d;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic irq_q;
   logic irq_d;
   logic [PW-1:0] pulse_q;
   logic [PW-1:0] pulse_d;
   logic restart;
   logic expire;

   assign restart = f_valid || v_valid;
   // Tick stops outside counting, so a stale tick cannot age a fresh period
   assign tb.run = (state_q == pwdt_pkg::PWDT_COUNT) && !restart;
   // Comparing before the increment makes a period of N ticks end on tick N
   assign expire = tb.tick && (count_q + CW'(1) >= period_q);

   always_comb begin
      state_d = state_q;
      irq_mode_d = irq_mode_q;
      period_d = period_q;
      count_d = count_q;
      irq_d = irq_q;
      // Pulse runs out on its own; a new factor does not cut it short
      pulse_d = (pulse_q != '0) ? pulse_q - PW'(1) : pulse_q;
      if (f_disable || var_dis_hit) begin
         state_d = pwdt_pkg::PWDT_IDLE;
         count_d = '0;
         irq_d = 1'b0;
      end else if (f_valid) begin
         state_d = pwdt_pkg::PWDT_COUNT;
         irq_mode_d = f_irq;
         period_d = f_period;
         count_d = '0;
         irq_d = 1'b0;
      end else if (v_valid) begin
         state_d = pwdt_pkg::PWDT_COUNT;
         irq_mode_d = 1'b0;
         period_d = v_period;
         count_d = '0;
         irq_d = 1'b0;
      end else begin
         unique case (state_q)
            pwdt_pkg::PWDT_IDLE: begin
               count_d = '0;
            end
            pwdt_pkg::PWDT_COUNT: begin
               if (tb.tick) begin
                  if (expire) begin
                     state_d = pwdt_pkg::PWDT_FIRED;
                     if (irq_mode_q) begin
                        irq_d = 1'b1;
                     end else begin
                        pulse_d = PULSE_LEN;
                     end
                  end else begin
                     count_d = count_q + CW'(1);
                  end
               end
            end
            pwdt_pkg::PWDT_FIRED: begin
               // Holds until software retriggers or disables
               count_d = count_q;
            end
            default: begin
               state_d = pwdt_pkg::PWDT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= pwdt_pkg::PWDT_IDLE;
         irq_mode_q <= 1'b0;
         period_q <= '0;
         count_q <= '0;
         irq_q <= 1'b0;
         pulse_q <= '0;
      end else begin
         state_q <= state_d;
         irq_mode_q <= irq_mode_d;
         period_q <= period_d;
         count_q <= count_d;
         irq_q <= irq_d;
         pulse_q <= pulse_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indicator LED, toggles every half second while counting
   logic [CW-1:0] led_cnt_q;
   logic [CW-1:0] led_cnt_d;
   logic led_q;
   logic led_d;
   // Blink phase survives retriggers so the LED keeps an even rhythm
   always_comb begin
      led_cnt_d = led_cnt_q;
      led_d = led_q;
      if (state_q != pwdt_pkg::PWDT_COUNT) begin
         led_cnt_d = '0;
         led_d = 1'b0;
      end else if (tb.tick) begin
         if (led_cnt_q + CW'(1) >= LED_T) begin
            led_cnt_d = '0;
            led_d = !led_q;
         end else begin
            led_cnt_d = led_cnt_q + CW'(1);
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         led_cnt_q <= '0;
         led_q <= 1'b0;
      end else begin
         led_cnt_q <= led_cnt_d;
         led_q <= led_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign watchdog_system_reset = (pulse_q != '0);
   assign watchdog_interrupt_line = irq_q;
   assign watchdog_led = led_q;
   assign watchdog_enabled = (state_q == pwdt_pkg::PWDT_COUNT);
endmodule : pwdt_top
`default_nettype wire

// ---- verification/pwdt_host_model.sv ----
// Partner model: host software writing the watchdog I/O ports
`timescale 1ns/100ps
`default_nettype none
module pwdt_host_model (
   input wire logic sys_clk,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_write
);
   logic busy = 1'b0;
   initial begin
      io_addr = 16'h0000;
      io_wdata = 8'h00;
      io_write = 1'b0;
   end
   // Idle bus is not held: stale address and data flip
   always @(negedge sys_clk) begin
      if (!busy) begin
         io_addr = ~io_addr;
         io_wdata = ~io_wdata;
      end
   end
   // One strobe per byte; callers rewrite only where a period is to be retriggered
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      busy = 1'b1;
      @(negedge sys_clk);
      io_addr = a;
      io_wdata = d;
      io_write = 1'b1;
      @(negedge sys_clk);
      io_write = 1'b0;
      busy = 1'b0;
   endtask : io_wr
endmodule : pwdt_host_model
`default_nettype wire

// ---- verification/pwdt_top_properties.sv ----
// Checker: port-level properties of the watchdog top
`timescale 1ns/100ps
`default_nettype none
module pwdt_top_properties #(
   parameter logic [15:0] BASE_PORT = 16'h0300,
   parameter int RESET_PULSE_CYCLES = 4
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_write,
   input wire logic watchdog_system_reset,
   input wire logic watchdog_interrupt_line,
   input wire logic watchdog_led,
   input wire logic watchdog_enabled
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic hit;
   logic [15:0] plen_d;
   logic [15:0] plen_q;
   assign hit = io_write && (io_addr == 16'h0076 || io_addr == BASE_PORT + 16'h0004);
   always_comb begin
      plen_d = watchdog_system_reset ? plen_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge sys_clk) begin
      plen_q <= reset ? 16'h0000 : plen_d;
   end
   a_reset_quiet: assert property ($past(reset) |-> !(watchdog_enabled || watchdog_system_reset ||
      watchdog_interrupt_line || watchdog_led)) else $error("outputs active after reset");
   a_enable_write: assert property (hit && io_wdata[7] && io_wdata[5:3] == 3'h0 |=>
      watchdog_enabled && !watchdog_interrupt_line) else $error("valid factor not taken");
   a_disable_write: assert property (hit && io_wdata == 8'h00 |=>
      !watchdog_enabled && !watchdog_interrupt_line) else $error("disable not taken");
   a_led_idle: assert property (!watchdog_enabled && !$past(watchdog_enabled) |-> !watchdog_led)
      else $error("led lit while idle");
   a_led_blinks: assert property ($rose(watchdog_enabled) |-> ##[1:70]
      ($changed(watchdog_led) || !watchdog_enabled)) else $error("led not blinking");
   a_pulse_length: assert property ($fell(watchdog_system_reset) |-> plen_q == RESET_PULSE_CYCLES)
      else $error("reset pulse length wrong");
   a_reset_expiry: assert property ($rose(watchdog_system_reset) |-> $fell(watchdog_enabled) &&
      !watchdog_interrupt_line) else $error("reset pulse without expiry");
   a_irq_holds: assert property (watchdog_interrupt_line && !io_write |=> watchdog_interrupt_line)
      else $error("interrupt dropped");
endmodule : pwdt_top_properties
bind pwdt_top pwdt_top_properties #(.BASE_PORT(BASE_PORT), .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) u_props (
   .sys_clk(sys_clk), .reset(reset), .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write),
   .watchdog_system_reset(watchdog_system_reset), .watchdog_interrupt_line(watchdog_interrupt_line),
   .watchdog_led(watchdog_led), .watchdog_enabled(watchdog_enabled));
`default_nettype wire

// ---- verification/programmable_watchdog_timer_bench.sv ----
// Testbench: watchdog timer driven by a host model, checked against a rule model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module programmable_watchdog_timer_bench;
   localparam int DIV = 10;
   localparam logic [15:0] BASE = 16'h0300;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] io_addr;
   logic [7:0] io_wdata;
   logic io_write, wsr, wirq, wled, wen;
   int n_mismatch = 0;
   int num_checks = 0;
   int n;
   logic [31:0] rng = 32'h24b2;
   bit m_en = 1'b0;
   bit m_irq = 1'b0;
   int exp_q[$];
   always #12.5 sys_clk = ~sys_clk;
   pwdt_host_model host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write));
   pwdt_top #(.BASE_PORT(BASE), .TICK_DIV(DIV), .RESET_PULSE_CYCLES(4)) dut (.sys_clk(sys_clk), .reset(reset),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write), .watchdog_system_reset(wsr),
      .watchdog_interrupt_line(wirq), .watchdog_led(wled), .watchdog_enabled(wen));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   // Cycles to expiry: short step, whole units, or variant units
   function automatic int period(input int idx, input int var_unit);
      return var_unit != 0 ? 93 * var_unit * DIV : (idx == 0 ? 30 : 60 * idx) * DIV;
   endfunction : period
   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // Rule model: each accepted write moves the expected enable; factor writes also set mode and period
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bit cmd;
      cmd = (a == 16'h0076 || a == BASE + 16'h0004);
      host.io_wr(a, d);
      if (cmd && d == 8'h00) begin
         m_en = 1'b0;
      end else if (cmd && d[7] && d[5:3] == 3'h0) begin
         m_en = 1'b1;
         m_irq = d[6];
         exp_q.push_back(period(d[2:0], 0));
      end else if (a == 16'h0441 && d == 8'hff) begin
         m_en = 1'b0;
      end else if (a == 16'h0443 && d >= 8'h01 && d <= 8'h04) begin
         m_en = 1'b1;
         m_irq = 1'b0;
         exp_q.push_back(period(0, d));
      end
      `CHK(wen, m_en)
   endtask : wr
   // Newest accepted period rules the expiry
   task automatic expire;
      int cyc;
      cyc = exp_q.size() > 0 ? exp_q[$] : 0;
      exp_q.delete();
      n = 0;
      while (wen === 1'b1 && n < 60000) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK(n >= cyc - 1 && n <= cyc + 3, 1'b1)
      `CHK(wsr, !m_irq)
      `CHK(wirq, m_irq)
      m_en = 1'b0;
   endtask : expire
   initial begin
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      @(negedge sys_clk);
      `CHK({wen, wsr, wirq, wled}, 4'h0)
      for (int i = 0; i < 16; i++) begin
         wr(i[0] ? BASE + 16'h0004 : 16'h0076, (i < 8 ? 8'h80 : 8'hc0) | 8'(i % 8));
         expire();
      end
      wr(16'h0076, 8'h81);
      repeat (3) begin
         repeat (400) @(negedge sys_clk);
         wr(16'h0076, 8'h81);
      end
      expire();
      wr(16'h0076, 8'h87);
      repeat (100) @(negedge sys_clk);
      wr(BASE + 16'h0004, 8'hc0);
      expire();
      wr(16'h0076, 8'h00);
      `CHK(wirq, 1'b0)
      // Interrupt mode: a missed disable would leave the line held high
      wr(16'h0076, 8'hc3);
      repeat (100) @(negedge sys_clk);
      wr(16'h0076, 8'h00);
      repeat (2000) @(negedge sys_clk);
      `CHK({wen, wsr, wirq}, 3'h0)
      repeat (20) begin
         rng = xs(rng);
         wr(16'h0076, {1'b0, rng[6:0] | 7'h01});
         `CHK(wen, 1'b0)
         wr(16'h0076, {1'b1, rng[14], rng[13:11] | 3'h1, rng[10:8]});
         `CHK(wen, 1'b0)
      end
      wr(16'h0443, 8'(rng[9:8]) + 8'h01);
      expire();
      wr(16'h0443, 8'h02);
      repeat (50) @(negedge sys_clk);
      wr(16'h0441, 8'hff);
      `CHK(wen, 1'b0)
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      end_of_test();
   end
endmodule : programmable_watchdog_timer_bench
`default_nettype wire
